// ==== uart_channel_register_map_test.sv ====
// Self-checking bench of the channel register map
module uart_channel_register_map_test import ucrm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in, resetn_in, wr, rd;
  logic [1:0] ch;
  logic [2:0] adr;
  logic [7:0] wd, rdata, txd, q;
  logic [3:0] txw;
  ucrm_stat_t [3:0] stat;
  ucrm_cfg_t [3:0] cfg;
  int err_count, check_count;
  ucrm_host_model i_host (.clk_in(clk_in), .rdata_in(rdata), .chan_out(ch), .addr_out(adr), .wr_out(wr),
    .rd_out(rd), .wdata_out(wd));
  ucrm_uart_channel_register_map #(.NUM_CH(4)) i_dut (.clk_in(clk_in), .resetn_in(resetn_in), .chan_sel_in(ch),
    .addr_in(adr), .wr_in(wr), .rd_in(rd), .wdata_in(wd), .stat_in(stat), .rdata_out(rdata), .cfg_out(cfg),
    .tx_wr_out(txw), .tx_data_out(txd), .rx_rd_out(), .isr_rd_out(), .lsr_rd_out(), .msr_rd_out());
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic w(input logic [1:0] c, input logic [2:0] a, input logic [7:0] d);
    i_host.access(1'b1, c, a, d, q);
  endtask : w
  task automatic r(input logic [1:0] c, input logic [2:0] a, input logic [7:0] e);
    i_host.access(1'b0, c, a, 8'h00, q);
    chk(q, e);
  endtask : r
  task automatic t_scratch();
    for (int c = 0; c < 4; c++) w(2'(c), 3'h7, 8'h50 + 8'(c));
    for (int c = 0; c < 4; c++) r(2'(c), 3'h7, 8'h50 + 8'(c));
    for (int c = 0; c < 4; c++) begin
      w(2'(c), 3'h0, 8'hC0 + 8'(c));
      chk({4'h0, txw}, 8'h01 << c);
      chk(txd, 8'hC0 + 8'(c));
    end
  endtask : t_scratch
  task automatic t_divisor();
    w(2'h1, 3'h3, 8'h83);
    w(2'h1, 3'h0, 8'h12);
    w(2'h1, 3'h1, 8'h34);
    r(2'h1, 3'h0, 8'h12);
    r(2'h1, 3'h1, 8'h34);
    chk(cfg[1].dll, 8'h12);
    r(2'h1, 3'h5, 8'h00);
    r(2'h1, 3'h3, 8'h83);
    w(2'h1, 3'h3, 8'h03);
    stat[1].rx_data = 8'h6B;
    r(2'h1, 3'h0, 8'h6B);
  endtask : t_divisor
  task automatic t_enhanced();
    w(2'h2, 3'h3, 8'hBF);
    w(2'h2, 3'h2, 8'hD0);
    r(2'h2, 3'h2, 8'hD0);
    for (int a = 4; a < 8; a++) w(2'h2, 3'(a), 8'h11 * 8'(a));
    for (int a = 4; a < 8; a++) r(2'h2, 3'(a), 8'h11 * 8'(a));
    w(2'h2, 3'h3, 8'h80);
    w(2'h2, 3'h2, 8'hFF);
    r(2'h2, 3'h2, 8'h3F);
    w(2'h2, 3'h3, 8'h00);
    w(2'h2, 3'h1, 8'hFF);
    r(2'h2, 3'h1, 8'hFF);
    w(2'h2, 3'h4, 8'hFF);
    r(2'h2, 3'h4, 8'hFF);
    w(2'h2, 3'h3, 8'hBF);
    w(2'h2, 3'h2, 8'h00);
    w(2'h2, 3'h3, 8'h00);
    r(2'h2, 3'h1, 8'h0F);
    r(2'h2, 3'h4, 8'h1F);
  endtask : t_enhanced
  task automatic t_status();
    stat[3] = {8'h00, 4'hC, 2'h3, 8'h61, 4'h0};
    w(2'h3, 3'h2, 8'h01);
    r(2'h3, 3'h2, 8'hCC);
    w(2'h3, 3'h3, 8'hBF);
    w(2'h3, 3'h2, 8'h10);
    w(2'h3, 3'h3, 8'h00);
    w(2'h3, 3'h2, 8'h31);
    r(2'h3, 3'h2, 8'hFC);
    r(2'h3, 3'h5, 8'h61);
    stat[3].modem = 4'h5;
    r(2'h3, 3'h6, 8'h55);
    r(2'h3, 3'h6, 8'h50);
  endtask : t_status
  task automatic t_reset();
    @(posedge clk_in);
    #1 resetn_in = 1'b0;
    repeat (2) @(posedge clk_in);
    #1 resetn_in = 1'b1;
    repeat (3) @(posedge clk_in);
    r(2'h0, 3'h7, 8'h00);
    r(2'h1, 3'h3, 8'h00);
    chk(cfg[1].dll, 8'h00);
    chk(txd, 8'h00);
  endtask : t_reset
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  initial begin
    err_count = 0;
    check_count = 0;
    resetn_in = 1'b0;
    stat = '0;
    repeat (16) @(posedge clk_in);
    #1 resetn_in = 1'b1;
    repeat (3) @(posedge clk_in);
    t_scratch();
    t_divisor();
    t_enhanced();
    t_status();
    t_reset();
    print_verdict();
  end
  initial begin
    #50000;
    err_count++;
    print_verdict();
  end
endmodule : uart_channel_register_map_test

// ==== ucrm_host_model.sv ====
// Host model driving the channel register bus
module ucrm_host_model (
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  output logic [1:0] chan_out,
  output logic [2:0] addr_out,
  output logic wr_out,
  output logic rd_out,
  output logic [7:0] wdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {chan_out, addr_out, wr_out, rd_out, wdata_out} = 15'h0000;
  end
  // One strobe cycle, bus inverted once released
  task automatic access(input logic w, input logic [1:0] c, input logic [2:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    @(posedge clk_in);
    #1;
    {chan_out, addr_out, wdata_out, wr_out, rd_out} = {c, a, d, w, !w};
    @(posedge clk_in);
    #1;
    q = rdata_in;
    {chan_out, addr_out, wdata_out, wr_out, rd_out} = {~c, ~a, ~d, 2'b00};
  endtask : access
endmodule : ucrm_host_model

// ==== ucrm_monitor.sv ====
// Checker of the channel register map ports
module ucrm_monitor
  import ucrm_pkg::*;
#(
  parameter int NUM_CH = 4
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [$clog2(NUM_CH)-1:0] chan_sel_in,
  input wire logic [2:0] addr_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] wdata_in,
  input wire ucrm_stat_t [NUM_CH-1:0] stat_in,
  input wire logic [7:0] rdata_out,
  input wire ucrm_cfg_t [NUM_CH-1:0] cfg_out,
  input wire logic [NUM_CH-1:0] tx_wr_out,
  input wire logic [7:0] tx_data_out,
  input wire logic [NUM_CH-1:0] rx_rd_out,
  input wire logic [NUM_CH-1:0] isr_rd_out,
  input wire logic [NUM_CH-1:0] lsr_rd_out,
  input wire logic [NUM_CH-1:0] msr_rd_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  ucrm_cfg_t cf;
  ucrm_stat_t st;
  logic [NUM_CH-1:0] one;
  assign cf = cfg_out[chan_sel_in];
  assign st = stat_in[chan_sel_in];
  assign one = NUM_CH'(1) << chan_sel_in;
  a_tx_pulse: assert property (
    wr_in && addr_in == 3'h0 && !cf.line_control[7] |=> tx_wr_out == $past(one) && tx_data_out == $past(wdata_in))
    else $error("tx write pulse wrong");
  a_rx_read: assert property (
    rd_in && addr_in == 3'h0 && !cf.line_control[7] |=> rx_rd_out == $past(one) && rdata_out == $past(st.rx_data))
    else $error("rx holding read wrong");
  a_lcr_write: assert property (
    wr_in && addr_in == 3'h3 |=> cfg_out[$past(chan_sel_in)].line_control == $past(wdata_in))
    else $error("line control write lost");
  a_div_low: assert property (
    wr_in && addr_in == 3'h0 && cf.line_control[7] && cf.line_control != 8'hBF |=> cfg_out[$past(chan_sel_in)].dll == $past(wdata_in))
    else $error("divisor low write lost");
  a_feature_write: assert property (
    wr_in && addr_in == 3'h2 && cf.line_control == 8'hBF |=> cfg_out[$past(chan_sel_in)].enhanced_feature == $past(wdata_in))
    else $error("feature write lost");
  a_flow_char: assert property (
    wr_in && addr_in == 3'h7 && cf.line_control == 8'hBF |=> cfg_out[$past(chan_sel_in)].flow_pause_char_2 == $past(wdata_in))
    else $error("flow character write lost");
  a_scratch_write: assert property (
    wr_in && addr_in == 3'h7 && cf.line_control != 8'hBF |=> cfg_out[$past(chan_sel_in)].scratch == $past(wdata_in))
    else $error("scratch write lost");
  a_ext_gated: assert property (
    !cf.enhanced_feature[4] |-> cf.interrupt_enable[7:4] == 4'h0 && cf.fifo_control[5:4] == 2'h0 && cf.modem_control[7:5] == 3'h0 && cf.baud_divisor_fraction == 8'h00)
    else $error("extended bits live while disabled");
  a_line_status: assert property (
    rd_in && addr_in == 3'h5 && !cf.line_control[7] |=> rdata_out == $past(st.line_status) && lsr_rd_out == $past(one))
    else $error("line status read wrong");
  a_modem_level: assert property (
    rd_in && addr_in == 3'h6 && cf.line_control != 8'hBF |=> rdata_out[7:4] == $past(st.modem) && msr_rd_out == $past(one))
    else $error("modem levels wrong");
  a_isr_fifo: assert property (
    rd_in && addr_in == 3'h2 && !cf.line_control[7] |=> rdata_out[7:6] == {2{$past(cf.fifo_control[0])}} && isr_rd_out == $past(one))
    else $error("status fifo bits wrong");
endmodule : ucrm_monitor

bind ucrm_uart_channel_register_map ucrm_monitor #(.NUM_CH(NUM_CH)) i_mon (.clk_in(clk_in), .resetn_in(resetn_in),
  .chan_sel_in(chan_sel_in), .addr_in(addr_in), .wr_in(wr_in), .rd_in(rd_in), .wdata_in(wdata_in),
  .stat_in(stat_in), .rdata_out(rdata_out), .cfg_out(cfg_out), .tx_wr_out(tx_wr_out), .tx_data_out(tx_data_out),
  .rx_rd_out(rx_rd_out), .isr_rd_out(isr_rd_out), .lsr_rd_out(lsr_rd_out), .msr_rd_out(msr_rd_out));

// ==== ucrm_pkg.sv ====
// Package: constants, types and decode for the channel register map
package ucrm_pkg;

  // ----------------------------------------
  // Register addresses inside a channel
  // ----------------------------------------
  localparam logic [2:0] ADR_DATA = 3'h0;
  localparam logic [2:0] ADR_IER = 3'h1;
  localparam logic [2:0] ADR_ISR = 3'h2;
  localparam logic [2:0] ADR_LCR = 3'h3;
  localparam logic [2:0] ADR_MCR = 3'h4;
  localparam logic [2:0] ADR_LSR = 3'h5;
  localparam logic [2:0] ADR_MSR = 3'h6;
  localparam logic [2:0] ADR_SPR = 3'h7;

  // ----------------------------------------
  // Field positions, masks, special values
  // ----------------------------------------
  localparam logic [7:0] LCR_ENHANCED = 8'hBF;
  localparam int LCR_DLAB_BIT = 7;
  localparam int EFR_EXT_BIT = 4;
  localparam int FCR_FIFO_EN_BIT = 0;
  localparam logic [7:0] IER_EXT_MASK = 8'hF0;
  localparam logic [7:0] FCR_EXT_MASK = 8'h30;
  localparam logic [7:0] MCR_EXT_MASK = 8'hE0;
  localparam logic [1:0] ISR_EXT_MASK = 2'h3;
  localparam logic [7:0] DLD_MASK = 8'h3F;
  localparam logic [7:0] RDATA_RESET = 8'h00;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [4:0] {
    SEL_DATA = 5'h00,
    SEL_IER = 5'h01,
    SEL_ISR = 5'h02,
    SEL_LCR = 5'h03,
    SEL_MCR = 5'h04,
    SEL_LSR = 5'h05,
    SEL_MSR = 5'h06,
    SEL_SPR = 5'h07,
    SEL_DLL = 5'h08,
    SEL_DLM = 5'h09,
    SEL_DLD = 5'h0A,
    SEL_EFR = 5'h0B,
    SEL_FLOW_RESUME_CHAR_1 = 5'h0C,
    SEL_FLOW_RESUME_CHAR_2 = 5'h0D,
    SEL_FLOW_PAUSE_CHAR_1 = 5'h0E,
    SEL_FLOW_PAUSE_CHAR_2 = 5'h0F,
    SEL_NONE = 5'h10
  } ucrm_sel_t;

  typedef struct packed {
    logic [7:0] interrupt_enable;
    logic [7:0] fifo_control;
    logic [7:0] line_control;
    logic [7:0] modem_control;
    logic [7:0] scratch;
    logic [7:0] dll;
    logic [7:0] baud_divisor_high;
    logic [7:0] baud_divisor_fraction;
    logic [7:0] enhanced_feature;
    logic [7:0] flow_resume_char_1;
    logic [7:0] flow_resume_char_2;
    logic [7:0] flow_pause_char_1;
    logic [7:0] flow_pause_char_2;
  } ucrm_cfg_t;

  typedef struct packed {
    logic [7:0] rx_data;
    logic [3:0] int_id;
    logic [1:0] int_ext;
    logic [7:0] line_status;
    logic [3:0] modem;
  } ucrm_stat_t;

  localparam ucrm_cfg_t CFG_RESET = '0;

  // ----------------------------------------
  // Address decode from line control value
  // ----------------------------------------
  function automatic ucrm_sel_t ucrm_decode(
    input logic [7:0] line_control,
    input logic [2:0] adr,
    input logic ext
  );
    ucrm_sel_t sel;
    sel = SEL_NONE;
    if (adr == ADR_LCR) begin
      sel = SEL_LCR;
    end else if (line_control == LCR_ENHANCED) begin
      if (adr == ADR_ISR) sel = SEL_EFR;
      else if (adr == ADR_MCR) sel = SEL_FLOW_RESUME_CHAR_1;
      else if (adr == ADR_LSR) sel = SEL_FLOW_RESUME_CHAR_2;
      else if (adr == ADR_MSR) sel = SEL_FLOW_PAUSE_CHAR_1;
      else if (adr == ADR_SPR) sel = SEL_FLOW_PAUSE_CHAR_2;
    end else if (line_control[LCR_DLAB_BIT]) begin
      if (adr == ADR_DATA) sel = SEL_DLL;
      else if (adr == ADR_IER) sel = SEL_DLM;
      else if (adr == ADR_ISR && ext) sel = SEL_DLD;
      else if (adr == ADR_MCR) sel = SEL_MCR;
      else if (adr == ADR_MSR) sel = SEL_MSR;
      else if (adr == ADR_SPR) sel = SEL_SPR;
    end else begin
      sel = ucrm_sel_t'({2'b00, adr});
    end
    return sel;
  endfunction : ucrm_decode

endpackage : ucrm_pkg

// ==== ucrm_uart_channel_register_map.sv ====
// Register file and address decoder of a four channel serial port
// Behaviour
// - Four channels, each its own register set
// - Extended bits live only while extension enabled
// - Address 0 data, address 2 status/FIFO control
// - Divisor bytes when access bit set, not 0xBF
// - Fraction register needs access bit and extension
// - Value 0xBF puts feature register at 2
// - Value 0xBF maps flow characters at 4-7
// - Interrupt enable field layout
// - FIFO control field layout
// - Line control field layout
// - Modem control field layout
// - Line status field layout
// - Modem status: change flags and levels
// - Scratch byte reads back last write
module ucrm_uart_channel_register_map
  import ucrm_pkg::*;
#(
  parameter int NUM_CH = 4
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [$clog2(NUM_CH)-1:0] chan_sel_in,
  input wire logic [2:0] addr_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] wdata_in,
  input wire ucrm_stat_t [NUM_CH-1:0] stat_in,
  output logic [7:0] rdata_out,
  output ucrm_cfg_t [NUM_CH-1:0] cfg_out,
  output logic [NUM_CH-1:0] tx_wr_out,
  output logic [7:0] tx_data_out,
  output logic [NUM_CH-1:0] rx_rd_out,
  output logic [NUM_CH-1:0] isr_rd_out,
  output logic [NUM_CH-1:0] lsr_rd_out,
  output logic [NUM_CH-1:0] msr_rd_out
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ----------------------------------------
  // Decode of the current access
  // ----------------------------------------
  ucrm_cfg_t [NUM_CH-1:0] cfg;
  logic [NUM_CH-1:0][3:0] delta;
  logic [NUM_CH-1:0][3:0] modem_prev;
  ucrm_cfg_t cur;
  ucrm_stat_t cur_st;
  logic cur_ext;
  ucrm_sel_t sel;

  assign cur = cfg[chan_sel_in];
  assign cur_st = stat_in[chan_sel_in];
  assign cur_ext = cur.enhanced_feature[EFR_EXT_BIT];
  assign sel = ucrm_decode(cur.line_control, addr_in, cur_ext);
  assign cfg_out = cfg;

  // ----------------------------------------
  // Extended bit gating
  // ----------------------------------------
  function automatic logic [7:0] ext_gate(
    input logic [7:0] data,
    input logic [7:0] mask,
    input logic ext
  );
    return ext ? data : (data & ~mask);
  endfunction : ext_gate

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= {NUM_CH{CFG_RESET}};
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (wr_in && chan_sel_in == ($clog2(NUM_CH))'(c)) begin
          case (sel)
            SEL_IER: begin
              cfg[c].interrupt_enable <= ext_gate(wdata_in, IER_EXT_MASK, cfg[c].enhanced_feature[EFR_EXT_BIT]);
            end
            SEL_ISR: begin
              cfg[c].fifo_control <= ext_gate(wdata_in, FCR_EXT_MASK, cfg[c].enhanced_feature[EFR_EXT_BIT]);
            end
            SEL_LCR: begin
              cfg[c].line_control <= wdata_in;
            end
            SEL_MCR: begin
              cfg[c].modem_control <= ext_gate(wdata_in, MCR_EXT_MASK, cfg[c].enhanced_feature[EFR_EXT_BIT]);
            end
            SEL_SPR: begin
              cfg[c].scratch <= wdata_in;
            end
            SEL_DLL: begin
              cfg[c].dll <= wdata_in;
            end
            SEL_DLM: begin
              cfg[c].baud_divisor_high <= wdata_in;
            end
            SEL_DLD: begin
              cfg[c].baud_divisor_fraction <= wdata_in & DLD_MASK;
            end
            SEL_EFR: begin
              cfg[c].enhanced_feature <= wdata_in;
              if (!wdata_in[EFR_EXT_BIT]) begin
                // Dropping the extension clears every extended bit
                cfg[c].interrupt_enable <= cfg[c].interrupt_enable & ~IER_EXT_MASK;
                cfg[c].fifo_control <= cfg[c].fifo_control & ~FCR_EXT_MASK;
                cfg[c].modem_control <= cfg[c].modem_control & ~MCR_EXT_MASK;
                cfg[c].baud_divisor_fraction <= 8'h00;
              end
            end
            SEL_FLOW_RESUME_CHAR_1: begin
              cfg[c].flow_resume_char_1 <= wdata_in;
            end
            SEL_FLOW_RESUME_CHAR_2: begin
              cfg[c].flow_resume_char_2 <= wdata_in;
            end
            SEL_FLOW_PAUSE_CHAR_1: begin
              cfg[c].flow_pause_char_1 <= wdata_in;
            end
            SEL_FLOW_PAUSE_CHAR_2: begin
              cfg[c].flow_pause_char_2 <= wdata_in;
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  // ----------------------------------------
  // Modem change flags
  // ----------------------------------------
  // Levels one cycle back, for change detection
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      modem_prev <= '0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        modem_prev[c] <= stat_in[c].modem;
      end
    end
  end

  // Change flags, cleared by a status read
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      delta <= '0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        // A change in the read cycle still sets its flag
        if (rd_in && sel == SEL_MSR && chan_sel_in == ($clog2(NUM_CH))'(c)) begin
          delta[c] <= stat_in[c].modem ^ modem_prev[c];
        end else begin
          delta[c] <= delta[c] | (stat_in[c].modem ^ modem_prev[c]);
        end
      end
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = 8'h00;
    if (sel == SEL_DATA) begin
      next_rdata = cur_st.rx_data;
    end else if (sel == SEL_IER) begin
      next_rdata = cur.interrupt_enable;
    end else if (sel == SEL_ISR) begin
      next_rdata = {cur.fifo_control[FCR_FIFO_EN_BIT], cur.fifo_control[FCR_FIFO_EN_BIT],
                    cur_st.int_ext & (cur_ext ? ISR_EXT_MASK : 2'h0),
                    cur_st.int_id};
    end else if (sel == SEL_LCR) begin
      next_rdata = cur.line_control;
    end else if (sel == SEL_MCR) begin
      next_rdata = cur.modem_control;
    end else if (sel == SEL_LSR) begin
      next_rdata = cur_st.line_status;
    end else if (sel == SEL_MSR) begin
      next_rdata = {cur_st.modem, delta[chan_sel_in]};
    end else if (sel == SEL_SPR) begin
      next_rdata = cur.scratch;
    end else if (sel == SEL_DLL) begin
      next_rdata = cur.dll;
    end else if (sel == SEL_DLM) begin
      next_rdata = cur.baud_divisor_high;
    end else if (sel == SEL_DLD) begin
      next_rdata = cur.baud_divisor_fraction;
    end else if (sel == SEL_EFR) begin
      next_rdata = cur.enhanced_feature;
    end else if (sel == SEL_FLOW_RESUME_CHAR_1) begin
      next_rdata = cur.flow_resume_char_1;
    end else if (sel == SEL_FLOW_RESUME_CHAR_2) begin
      next_rdata = cur.flow_resume_char_2;
    end else if (sel == SEL_FLOW_PAUSE_CHAR_1) begin
      next_rdata = cur.flow_pause_char_1;
    end else if (sel == SEL_FLOW_PAUSE_CHAR_2) begin
      next_rdata = cur.flow_pause_char_2;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rdata_out <= RDATA_RESET;
    end else if (rd_in) begin
      rdata_out <= next_rdata;
    end
  end

  // ----------------------------------------
  // Access pulses toward the serial engine
  // ----------------------------------------
  logic [NUM_CH-1:0] chan_hit;
  logic data_wr;
  logic data_rd;
  logic isr_rd;
  logic lsr_rd;
  logic msr_rd;

  always_comb begin
    chan_hit = '0;
    chan_hit[chan_sel_in] = 1'b1;
  end

  assign data_wr = wr_in && sel == SEL_DATA;
  assign data_rd = rd_in && sel == SEL_DATA;
  assign isr_rd = rd_in && sel == SEL_ISR;
  assign lsr_rd = rd_in && sel == SEL_LSR;
  assign msr_rd = rd_in && sel == SEL_MSR;

  // Write strobe of the transmit holding register
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      tx_wr_out <= '0;
    end else begin
      tx_wr_out <= data_wr ? chan_hit : '0;
    end
  end

  // Byte for the transmitter, held until the next data write
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      tx_data_out <= 8'h00;
    end else if (data_wr) begin
      tx_data_out <= wdata_in;
    end
  end

  // Read strobe of the receive holding register
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rx_rd_out <= '0;
    end else begin
      rx_rd_out <= data_rd ? chan_hit : '0;
    end
  end

  // Read strobe of interrupt status
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      isr_rd_out <= '0;
    end else begin
      isr_rd_out <= isr_rd ? chan_hit : '0;
    end
  end

  // Read strobe of line status
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      lsr_rd_out <= '0;
    end else begin
      lsr_rd_out <= lsr_rd ? chan_hit : '0;
    end
  end

  // Read strobe of modem status
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      msr_rd_out <= '0;
    end else begin
      msr_rd_out <= msr_rd ? chan_hit : '0;
    end
  end

endmodule : ucrm_uart_channel_register_map
